// ===== include/tpc_pkg.sv
// Purpose: shared constants and types for the pwm / carrier timer and its controller
// Assumes: one clock, hclk at 20 MHz
// Notes: the controller holds its own AHB-Lite register map
`default_nettype none
package tpc_pkg;

	// -------------------------------------------------------------------
	// operating modes
	// -------------------------------------------------------------------
	typedef enum logic [1:0] {
		TPC_MODE_IDLE,
		TPC_MODE_PWM,
		TPC_MODE_CARRIER
	} tpc_mode_t;

	localparam int unsigned TPC_CNT_W        = 8;
	localparam logic [7:0]  TPC_CNT_ZERO     = 8'h00;
	localparam logic [7:0]  TPC_CNT_ONE      = 8'h01;
	localparam logic [1:0]  TPC_LOAD_GUARD   = 2'h3;   // count clocks before a new duty value may load
	localparam logic [1:0]  TPC_XFER_DELAY   = 2'h2;   // clocks from strobe edge to enable copy

	// -------------------------------------------------------------------
	// controller register map (byte addresses)
	// -------------------------------------------------------------------
	localparam logic [7:0] TPC_REG_CTRL      = 8'h00;  // [0] count enable [2:1] mode [3] default level
	localparam logic [7:0] TPC_REG_CYCLE     = 8'h04;  // cycle / carrier low compare
	localparam logic [7:0] TPC_REG_DUTY      = 8'h08;  // duty / carrier high compare
	localparam logic [7:0] TPC_REG_CARRIER   = 8'h0C;  // [0] active (ro) [1] staged [2] remote enable
	localparam logic [7:0] TPC_REG_STATUS    = 8'h10;  // [0] output [1] match seen [2] strobe seen, w1c
	localparam logic [7:0] TPC_REG_EVENT     = 8'h14;  // write: pulse companion event

	localparam int unsigned TPC_CTRL_EN      = 0;
	localparam int unsigned TPC_CTRL_MODE_LO = 1;
	localparam int unsigned TPC_CTRL_MODE_HI = 2;
	localparam int unsigned TPC_CTRL_LEV     = 3;
	localparam int unsigned TPC_CAR_ACT      = 0;
	localparam int unsigned TPC_CAR_STG      = 1;
	localparam int unsigned TPC_CAR_RMT      = 2;
	localparam int unsigned TPC_ST_OUT       = 0;
	localparam int unsigned TPC_ST_MATCH     = 1;
	localparam int unsigned TPC_ST_STROBE    = 2;

	localparam logic [1:0] TPC_HTRANS_NONSEQ = 2'h2;

endpackage
`default_nettype wire

// ===== include/tpc_link_if.sv
// Purpose: connection between the timer core and its controller
// Assumes: both ends on hclk
// Notes: all signals are levels except the write strobes, event pulse, match interrupt pulse and three-clock strobe_seen pulse
`timescale 1ns/1ns
`default_nettype none
interface tpc_link_if;
	logic                 count_enable_bit;
	tpc_pkg::tpc_mode_t   mode;
	logic                 default_level_select;
	logic [7:0]           cycle_wdata;
	logic                 cycle_we;
	logic [7:0]           duty_wdata;
	logic                 duty_we;
	logic                 staged_wdata;
	logic                 staged_we;
	logic                 remote_output_enable;
	logic                 companion_event;
	logic                 timer_match_irq;
	logic                 timer_output_pin;
	logic                 active_carrier_enable;
	logic                 staged_carrier_enable;
	logic                 strobe_seen;

	modport core (
		input  count_enable_bit, mode, default_level_select, cycle_wdata, cycle_we,
		input  duty_wdata, duty_we, staged_wdata, staged_we, remote_output_enable,
		input  companion_event,
		output timer_match_irq, timer_output_pin, active_carrier_enable,
		output staged_carrier_enable, strobe_seen
	);
	modport ctrl (
		output count_enable_bit, mode, default_level_select, cycle_wdata, cycle_we,
		output duty_wdata, duty_we, staged_wdata, staged_we, remote_output_enable,
		output companion_event,
		input  timer_match_irq, timer_output_pin, active_carrier_enable,
		input  staged_carrier_enable, strobe_seen
	);
endinterface
`default_nettype wire

// ===== logic/tpc_core.sv
// Purpose: 8-bit compare timer with pwm and carrier generator modes
// Assumes: hclk is the count clock; companion_event may be asynchronous
// Notes: the interrupt output is a one-clock pulse per cycle/low/high match
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// [RL1] keep cycle compare fixed while pwm runs
// [RL2] duty compare writable while counter runs
// [RL3] one masked clock after enable, output inactive
// [RL4] cycle match clears, interrupts, active, selects duty
// [RL5] duty match inactive, selects cycle, no clear
// [RL6] disable resets interrupt and output level
// [RL7] duty below cycle, both eight bits
// [RL8] new duty loads at match after three clocks
// [RL9] carrier: first compare low, second high width
// [RL10] carrier high writable, low fixed while running
// [RL11] staged zero low, remote selects high or pulses
// [RL12] active enable read-only, staged read-write
// [RL13] companion event synchronised into transfer strobe
// [RL14] staged copies to active second clock after
// [RL15] wait two clocks between staged writes
// [RL16] software reloads staged value after each strobe
// [RL17] strobe stays internal, no interrupt source
// [RL18] carrier matches both interrupt and clear counter
// [RL19] carrier appears only while active enable high
// [RL20] mode bit chooses default output level
// [RL21] pwm active level inverts the default level
module tpc_core (
	input  wire logic hclk,
	input  wire logic hresetn,
	tpc_link_if.core  lnk
);

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] cmp_a;        // cycle or carrier low compare
		logic [7:0] cmp_b;        // duty or carrier high compare in use
		logic [7:0] cmp_b_latch;  // new value waiting for transfer
		logic       pend;         // latch holds an untransferred value
		logic [1:0] age;          // clocks since the latch was written
		logic       run;          // counting (past the masked clock)
		logic       sel_b;        // comparing against cmp_b
		logic       wave;         // 1 = active / high phase
		logic       irq;
		logic       ev_s1;
		logic       ev_s2;
		logic       ev_s3;        // previous synced value for edge detect
		logic [1:0] xfer;         // countdown to enable copy
		logic       stg;
		logic       act;
		logic       seen;
		logic       out;
	} tpc_core_st_t;

	tpc_core_st_t st_r;
	tpc_core_st_t st_nxt;
	logic         match;
	logic         load_ok;

	// -------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------
	// compare selects the active register of the pair
	assign match   = st_r.run && (st_r.cnt == (st_r.sel_b ? st_r.cmp_b : st_r.cmp_a));
	assign load_ok = st_r.pend && (st_r.age >= tpc_pkg::TPC_LOAD_GUARD);

	always_comb begin
		st_nxt     = st_r;
		st_nxt.irq = 1'b0;

		// compare registers; the low/cycle one is held constant by software
		if (lnk.cycle_we) begin
			st_nxt.cmp_a = lnk.cycle_wdata;
		end
		// [RL2] duty write latched
		if (lnk.duty_we) begin
			st_nxt.cmp_b_latch = lnk.duty_wdata;
			st_nxt.pend        = 1'b1;
			st_nxt.age         = 2'h0;
			// reloading while stopped takes effect at once
			if (!lnk.count_enable_bit) begin
				st_nxt.cmp_b = lnk.duty_wdata;
				st_nxt.pend  = 1'b0;
			end
		end else if (st_r.pend && st_r.age != tpc_pkg::TPC_LOAD_GUARD) begin
			st_nxt.age = st_r.age + 2'h1;
		end

		if (!lnk.count_enable_bit || lnk.mode == tpc_pkg::TPC_MODE_IDLE) begin
			// [RL6] stop: default levels
			st_nxt.run   = 1'b0;
			st_nxt.cnt   = tpc_pkg::TPC_CNT_ZERO;
			st_nxt.sel_b = 1'b0;
			st_nxt.wave  = 1'b0;
		end else if (!st_r.run) begin
			// [RL3] masked clock, output stays inactive
			st_nxt.run = 1'b1;
		end else if (match) begin
			// [RL8] duty latch loads on match of old value
			if (st_r.sel_b && load_ok) begin
				st_nxt.cmp_b = st_r.cmp_b_latch;
				st_nxt.pend  = 1'b0;
			end
			st_nxt.sel_b = !st_r.sel_b;
			// [RL9] low phase on first, high on second
			st_nxt.wave  = !st_r.sel_b;
			if (lnk.mode == tpc_pkg::TPC_MODE_CARRIER || !st_r.sel_b) begin
				// [RL4] [RL18] clear and interrupt
				st_nxt.cnt = tpc_pkg::TPC_CNT_ZERO;
				st_nxt.irq = 1'b1;
			end else begin
				// [RL5] duty match keeps counting
				st_nxt.cnt = st_r.cnt + tpc_pkg::TPC_CNT_ONE;
			end
		end else begin
			st_nxt.cnt = st_r.cnt + tpc_pkg::TPC_CNT_ONE;
		end

		// [RL13] two-stage synchroniser, edge from the second stage
		st_nxt.ev_s1 = lnk.companion_event;
		st_nxt.ev_s2 = st_r.ev_s1;
		st_nxt.ev_s3 = st_r.ev_s2;
		// [RL12] staged bit written by software only
		if (lnk.staged_we) begin
			st_nxt.stg = lnk.staged_wdata;
		end
		// [RL14] copy on second clock after strobe edge
		if (st_r.ev_s2 && !st_r.ev_s3) begin
			st_nxt.xfer = tpc_pkg::TPC_XFER_DELAY;
			st_nxt.seen = 1'b1;
		end else if (st_r.xfer != 2'h0) begin
			st_nxt.xfer = st_r.xfer - 2'h1;
			if (st_r.xfer == 2'h1) begin
				st_nxt.act = st_r.stg;
			end
		end else begin
			st_nxt.seen = 1'b0;
		end

		// output select
		if (lnk.mode == tpc_pkg::TPC_MODE_CARRIER) begin
			// [RL11] [RL19] gated carrier, low while inactive
			st_nxt.out = st_nxt.act && (!lnk.remote_output_enable || st_nxt.wave);
		end else begin
			// [RL20] [RL21] default level and its inverse
			st_nxt.out = lnk.default_level_select ^ st_nxt.wave;
		end
	end

	// -------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// [RL17] strobe kept off the interrupt output
	assign lnk.timer_match_irq       = st_r.irq;
	assign lnk.timer_output_pin      = st_r.out;
	assign lnk.active_carrier_enable = st_r.act;
	assign lnk.staged_carrier_enable = st_r.stg;
	assign lnk.strobe_seen           = st_r.seen;

endmodule // tpc_core
`default_nettype wire

// ===== logic/tpc_ctrl.sv
// Purpose: AHB-Lite register controller driving the timer core
// Assumes: single word transfers, zero wait states on writes, one on reads
// Notes: writes are applied at the data phase edge
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module tpc_ctrl (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	tpc_link_if.ctrl         lnk
);

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	typedef struct packed {
		logic       wr_ph;
		logic       rd_ph;
		logic [7:0] addr;
		logic       en;
		logic [1:0] mode;
		logic       lev;
		logic [7:0] cyc;
		logic [7:0] duty;
		logic       rmt;
		logic       mseen;
		logic       sseen;
		logic       cyc_we;
		logic       duty_we;
		logic       stg_we;
		logic       stg_d;
		logic       ev;
		logic [31:0] rdata;
	} tpc_ctrl_st_t;

	tpc_ctrl_st_t st_r;
	tpc_ctrl_st_t st_nxt;
	logic         take;
	logic [31:0]  rd_mux;

	// -------------------------------------------------------------------
	// bus decode and registers
	// -------------------------------------------------------------------
	assign take = hsel && hready && (htrans == tpc_pkg::TPC_HTRANS_NONSEQ);

	always_comb begin
		rd_mux = 32'h00000000;
		unique case (st_r.addr)
			tpc_pkg::TPC_REG_CTRL:    rd_mux = {28'h0000000, st_r.lev, st_r.mode, st_r.en};
			tpc_pkg::TPC_REG_CYCLE:   rd_mux = {24'h000000, st_r.cyc};
			tpc_pkg::TPC_REG_DUTY:    rd_mux = {24'h000000, st_r.duty};
			tpc_pkg::TPC_REG_CARRIER: rd_mux = {29'h0, st_r.rmt,
				lnk.staged_carrier_enable, lnk.active_carrier_enable};
			tpc_pkg::TPC_REG_STATUS:  rd_mux = {29'h0, st_r.sseen, st_r.mseen,
				lnk.timer_output_pin};
			default:                  rd_mux = 32'h00000000;
		endcase
	end

	always_comb begin
		st_nxt         = st_r;
		st_nxt.cyc_we  = 1'b0;
		st_nxt.duty_we = 1'b0;
		st_nxt.stg_we  = 1'b0;
		st_nxt.ev      = 1'b0;
		st_nxt.wr_ph   = take && hwrite;
		st_nxt.rd_ph   = take && !hwrite;
		if (take) begin
			st_nxt.addr = haddr[7:0];
		end
		if (st_r.rd_ph) begin
			st_nxt.rdata = rd_mux;
		end
		if (st_r.wr_ph) begin
			unique case (st_r.addr)
				tpc_pkg::TPC_REG_CTRL: begin
					st_nxt.en   = hwdata[tpc_pkg::TPC_CTRL_EN];
					st_nxt.mode = hwdata[tpc_pkg::TPC_CTRL_MODE_HI:tpc_pkg::TPC_CTRL_MODE_LO];
					st_nxt.lev  = hwdata[tpc_pkg::TPC_CTRL_LEV];
				end
				// [RL1] [RL10] software keeps this fixed while running
				tpc_pkg::TPC_REG_CYCLE: begin
					st_nxt.cyc    = hwdata[7:0];
					st_nxt.cyc_we = 1'b1;
				end
				// [RL7] software keeps duty below cycle
				tpc_pkg::TPC_REG_DUTY: begin
					st_nxt.duty    = hwdata[7:0];
					st_nxt.duty_we = 1'b1;
				end
				// [RL15] [RL16] staged write after each strobe, spaced
				tpc_pkg::TPC_REG_CARRIER: begin
					st_nxt.rmt    = hwdata[tpc_pkg::TPC_CAR_RMT];
					st_nxt.stg_d  = hwdata[tpc_pkg::TPC_CAR_STG];
					st_nxt.stg_we = 1'b1;
				end
				tpc_pkg::TPC_REG_EVENT: begin
					st_nxt.ev = 1'b1;
				end
				default: begin
				end
			endcase
		end
		// sticky flags: set wins over write-one-to-clear
		if (st_r.wr_ph && st_r.addr == tpc_pkg::TPC_REG_STATUS) begin
			if (hwdata[tpc_pkg::TPC_ST_MATCH]) st_nxt.mseen = 1'b0;
			if (hwdata[tpc_pkg::TPC_ST_STROBE]) st_nxt.sseen = 1'b0;
		end
		if (lnk.timer_match_irq) st_nxt.mseen = 1'b1;
		if (lnk.strobe_seen) st_nxt.sseen = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// -------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------
	assign hrdata                   = st_r.rdata;
	assign hreadyout                = !st_r.rd_ph;
	assign hresp                    = 1'b0;
	assign lnk.count_enable_bit     = st_r.en;
	assign lnk.mode                 = tpc_pkg::tpc_mode_t'(st_r.mode);
	assign lnk.default_level_select = st_r.lev;
	assign lnk.cycle_wdata          = st_r.cyc;
	assign lnk.cycle_we             = st_r.cyc_we;
	assign lnk.duty_wdata           = st_r.duty;
	assign lnk.duty_we              = st_r.duty_we;
	assign lnk.staged_wdata         = st_r.stg_d;
	assign lnk.staged_we            = st_r.stg_we;
	assign lnk.remote_output_enable = st_r.rmt;
	assign lnk.companion_event      = st_r.ev;

endmodule // tpc_ctrl
`default_nettype wire

// ===== tb/tpc_properties.sv
// Purpose: concurrent checks on the link between timer core and controller
// Assumes: one clock domain, hclk, async active-low reset
// Notes: takes the link signals as plain inputs
`timescale 1ns/1ns
`default_nettype none
module tpc_properties (
	input wire logic               hclk,
	input wire logic               hresetn,
	input wire logic               count_enable_bit,
	input wire tpc_pkg::tpc_mode_t mode,
	input wire logic               default_level_select,
	input wire logic               remote_output_enable,
	input wire logic               companion_event,
	input wire logic               timer_match_irq,
	input wire logic               timer_output_pin,
	input wire logic               active_carrier_enable,
	input wire logic               staged_carrier_enable,
	input wire logic               strobe_seen
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	logic pwm;
	logic car;
	logic act;
	// mode decode and pwm active level
	assign pwm = (mode == tpc_pkg::TPC_MODE_PWM);
	assign car = (mode == tpc_pkg::TPC_MODE_CARRIER);
	assign act = timer_output_pin ^ default_level_select;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence strobe_up_s;
		##[2:4] strobe_seen;
	endsequence
	sequence copy_s;
		##2 (active_carrier_enable == staged_carrier_enable);
	endsequence

	irq_pulse_a: assert property (timer_match_irq |=> !timer_match_irq)
		else $error("match pulse longer than one cycle");
	masked_start_a: assert property (pwm && $rose(count_enable_bit) |=> !act [*3])
		else $error("pwm output active during masked start");
	pwm_active_a: assert property (pwm && count_enable_bit && $past(count_enable_bit) && $rose(act)
		|-> ##[0:1] timer_match_irq)
		else $error("active level without match pulse");
	duty_quiet_a: assert property (pwm && count_enable_bit && $fell(act)
		|-> !timer_match_irq)
		else $error("duty match raised a match pulse");
	disable_idle_a: assert property (pwm && $fell(count_enable_bit)
		|=> (!timer_match_irq && !act) [*2])
		else $error("disable left pulse or active level");
	idle_level_a: assert property (pwm && !count_enable_bit && !$past(count_enable_bit, 2)
		&& $stable(default_level_select) && $stable(mode) |-> !act)
		else $error("stopped pwm output not at default level");
	strobe_sync_a: assert property (companion_event |-> strobe_up_s)
		else $error("companion event not turned into strobe");
	strobe_copy_a: assert property ($rose(strobe_seen) |-> copy_s)
		else $error("staged enable not copied after strobe");
	stopped_quiet_a: assert property (!count_enable_bit && !$past(count_enable_bit)
		|-> !timer_match_irq)
		else $error("match pulse while stopped");
	carrier_irq_a: assert property (car && count_enable_bit && $past(count_enable_bit)
		&& active_carrier_enable && $past(active_carrier_enable, 2) && remote_output_enable
		&& $changed(timer_output_pin) |-> ##[0:1] timer_match_irq)
		else $error("carrier edge without match pulse");
	carrier_gate_a: assert property (car && $stable(mode) && !active_carrier_enable
		&& !$past(active_carrier_enable) |-> !timer_output_pin)
		else $error("carrier output while disabled");
	carrier_level_a: assert property (car && active_carrier_enable
		&& $past(active_carrier_enable, 2) && !remote_output_enable |-> timer_output_pin)
		else $error("carrier output not high without remote");
endmodule // tpc_properties
`default_nettype wire

// ===== tb/timer_pwm_carrier_generator_test.sv
// Purpose: self-checking bench, controller and core joined by the link
// Assumes: hclk 20 MHz, AHB-Lite single word transfers
// Notes: output counts while running are taken over one full period, the stopped pwm count over 4 cycles
`timescale 1ns/1ns
`default_nettype none
module timer_pwm_carrier_generator_test;
	// ---------------------------------------------------------------
	// signals and instances
	// ---------------------------------------------------------------
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	int          mismatches;
	int          n_tests;

	tpc_link_if lnk ();
	tpc_core tpc_core_inst (.hclk(hclk), .hresetn(hresetn), .lnk(lnk.core));
	tpc_ctrl tpc_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lnk(lnk.ctrl));
	tpc_properties tpc_properties_inst (.hclk(hclk), .hresetn(hresetn),
		.count_enable_bit(lnk.count_enable_bit), .mode(lnk.mode),
		.default_level_select(lnk.default_level_select),
		.remote_output_enable(lnk.remote_output_enable), .companion_event(lnk.companion_event),
		.timer_match_irq(lnk.timer_match_irq), .timer_output_pin(lnk.timer_output_pin),
		.active_carrier_enable(lnk.active_carrier_enable),
		.staged_carrier_enable(lnk.staged_carrier_enable), .strobe_seen(lnk.strobe_seen));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single transfer, read data left in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= tpc_pkg::TPC_HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask

	// count output samples at level lv and match pulses over len cycles
	task automatic meas(input int len, input logic lv, input int hi, input int irq);
		int h;
		int q;
		h = 0;
		q = 0;
		repeat (len) begin
			@(negedge hclk);
			h += (lnk.timer_output_pin === lv);
			q += (lnk.timer_match_irq === 1'h1);
		end
		chk(h, hi);
		chk(q, irq);
	endtask

	task automatic wait_act(input logic v);
		int i;
		for (i = 0; i < 20 && lnk.active_carrier_enable !== v; i++) @(posedge hclk);
		chk(lnk.active_carrier_enable, v);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	// pwm, cycle 4 duty 1 then duty 2 while running, then stop
	task automatic pwm_run(input logic lv);
		bus(1'h1, tpc_pkg::TPC_REG_CYCLE, 32'h4);
		bus(1'h1, tpc_pkg::TPC_REG_DUTY, 32'h1);
		bus(1'h1, tpc_pkg::TPC_REG_CTRL, {28'h0, lv, 3'h3});
		repeat (12) @(posedge hclk);
		meas(5, ~lv, 2, 1);
		bus(1'h1, tpc_pkg::TPC_REG_DUTY, 32'h2);
		repeat (12) @(posedge hclk);
		meas(5, ~lv, 3, 1);
		bus(1'h1, tpc_pkg::TPC_REG_CTRL, {28'h0, lv, 3'h2});
		repeat (2) @(posedge hclk);
		meas(4, lv, 4, 0);
	endtask

	// carrier, low compare 2 (3 clocks) high compare 3 (4 clocks), level then pulses then off
	task automatic car_run();
		bus(1'h1, tpc_pkg::TPC_REG_CYCLE, 32'h2);
		bus(1'h1, tpc_pkg::TPC_REG_DUTY, 32'h3);
		bus(1'h1, tpc_pkg::TPC_REG_CARRIER, 32'h3);
		bus(1'h0, tpc_pkg::TPC_REG_CARRIER, 32'h0);
		chk(rd, 32'h2);
		bus(1'h1, tpc_pkg::TPC_REG_CTRL, 32'h5);
		bus(1'h1, tpc_pkg::TPC_REG_EVENT, 32'h1);
		wait_act(1'h1);
		repeat (4) @(posedge hclk);
		meas(7, 1'h1, 7, 2);
		bus(1'h0, tpc_pkg::TPC_REG_CARRIER, 32'h0);
		chk(rd, 32'h3);
		bus(1'h1, tpc_pkg::TPC_REG_CTRL, 32'h4);
		bus(1'h1, tpc_pkg::TPC_REG_CARRIER, 32'h6);
		bus(1'h1, tpc_pkg::TPC_REG_EVENT, 32'h1);
		bus(1'h1, tpc_pkg::TPC_REG_DUTY, 32'h3);
		bus(1'h1, tpc_pkg::TPC_REG_CTRL, 32'h5);
		wait_act(1'h1);
		repeat (12) @(posedge hclk);
		meas(7, 1'h1, 4, 2);
		bus(1'h1, tpc_pkg::TPC_REG_CARRIER, 32'h4);
		bus(1'h1, tpc_pkg::TPC_REG_EVENT, 32'h1);
		wait_act(1'h0);
		repeat (3) @(posedge hclk);
		meas(7, 1'h1, 0, 2);
		bus(1'h0, tpc_pkg::TPC_REG_STATUS, 32'h0);
		chk(rd[2], 1'h1);
		chk(rd[1:0], 32'h2);
		bus(1'h1, tpc_pkg::TPC_REG_STATUS, 32'h4);
		bus(1'h0, tpc_pkg::TPC_REG_STATUS, 32'h0);
		chk(rd[2], 1'h0);
		bus(1'h0, 8'h18, 32'h0);
		chk(rd, 32'h0);
		chk(hresp, 32'h0);
	endtask

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// clock, sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		hclk = 1'h0;
		forever #25 hclk = ~hclk;
	end

	initial begin
		hresetn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		mismatches = 0;
		n_tests = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
		pwm_run(1'h0);
		pwm_run(1'h1);
		car_run();
		results();
	end

	initial begin
		repeat (5000) @(posedge hclk);
		mismatches++;
		results();
	end
endmodule // timer_pwm_carrier_generator_test
`default_nettype wire
